// *** eic_top.sv ***
/*
 * external interrupt configuration block: pin/polarity register, the
 * four edge/pending bits of the timer control register, the extended
 * priority two register and a two-level request classifier.
 * assumes a special-function register bus on i_mclk, port pins that are
 * asynchronous, and a cpu that pulses a vector acknowledge per external interrupt.
 */
// Notes on behaviour
// - upper four bits of extended priority two read zero, writes ignored
// - bit 3 sets second serial peripheral interrupt priority, 1 high
// - bit 2 sets oscillator-fail interrupt priority, 1 high
// - bit 1 sets port-match interrupt priority, 1 high
// - bit 0 sets supply early-warning interrupt priority, 1 high
// - each external interrupt has own polarity and edge/level choice, 1 edge
// - config bit 7: second external interrupt polarity, 1 active high
// - config bit 3: first external interrupt polarity, 1 active high
// - bits 6:4 pick which port-0 pin feeds second external interrupt
// - bits 2:0 pick which port-0 pin feeds first external interrupt
// - selected pins are only observed, never driven or disturbed
// - timer control bits 1 and 3 are the two pending flags
// - edge mode: flag clears when the cpu vectors to that routine
// - level mode: flag mirrors whether the input is at active level
`timescale 1ns/1ps
`default_nettype none

module eic_top
    import eic_pkg::*;
(
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    // special-function register bus
    input  wire logic [7:0]                i_sfr_addr,
    input  wire logic                      i_sfr_wr,
    input  wire logic [7:0]                i_sfr_wdata,
    input  wire logic                      i_sfr_rd,
    output logic      [7:0]                o_sfr_rdata,
    // port 0 pins, observe only
    input  wire logic [EIC_PORT_WIDTH-1:0] i_port0_pins,
    // cpu vectoring
    input  wire logic                      i_ext_irq_a_vector_ack,
    input  wire logic                      i_ext_irq_b_vector_ack,
    input  wire logic                      i_ext_irq_a_high_pri,
    input  wire logic                      i_ext_irq_b_high_pri,
    input  wire logic                      i_low_service_active,
    // on-chip sources steered by extended priority two
    input  wire logic                      i_serial_periph_two_req,
    input  wire logic                      i_rtc_osc_fail_req,
    input  wire logic                      i_port_match_req,
    input  wire logic                      i_supply_warning_req,
    // pending flags and priority outputs
    output logic                           o_ext_irq_a_pending,
    output logic                           o_ext_irq_b_pending,
    output logic                           o_serial_periph_two_priority,
    output logic                           o_rtc_osc_fail_priority,
    output logic                           o_port_match_priority,
    output logic                           o_supply_warning_priority,
    // classified requests toward the cpu
    output logic                           o_high_req,
    output logic                           o_low_req,
    output logic                           o_preempt_req
);

    logic [EIC_PORT_WIDTH-1:0] pins_meta_r;
    logic [EIC_PORT_WIDTH-1:0] pins_sync_r;
    logic [7:0]                pin_pol_cfg_r;
    logic [EIC_PRIO_WIDTH-1:0] ext_prio_two_r;
    logic                      ext_irq_a_edge_mode_r;
    logic                      ext_irq_b_edge_mode_r;
    logic                      wr_cfg;
    logic                      wr_prio;
    logic                      wr_tctl;
    logic [7:0]                rd_mux;
    logic [5:0]                src_req;
    logic [5:0]                src_high;
    logic                      high_req_r;
    logic                      low_req_r;
    logic                      preempt_r;

    ////////////////////////////////////////////////////////////////////////
    // address match helper
    function automatic logic eic_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        eic_hit = (addr == reg_addr);
    endfunction : eic_hit

    assign wr_cfg  = i_sfr_wr & eic_hit(i_sfr_addr, EIC_ADDR_PIN_POL_CFG);
    assign wr_prio = i_sfr_wr & eic_hit(i_sfr_addr, EIC_ADDR_EXT_PRIO_TWO);
    assign wr_tctl = i_sfr_wr & eic_hit(i_sfr_addr, EIC_ADDR_TIMER_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser on the port pins
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pins_meta_r <= '0;
            pins_sync_r <= '0;
        end else begin
            pins_meta_r <= i_port0_pins;
            pins_sync_r <= pins_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin selection and polarity register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_pol_cfg_r <= EIC_RST_PIN_POL_CFG;
        end else if (wr_cfg) begin
            pin_pol_cfg_r <= i_sfr_wdata;
        end
    end

    // extended priority two, only low nibble stored
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ext_prio_two_r <= EIC_RST_EXT_PRIO_TWO;
        end else if (wr_prio) begin
            ext_prio_two_r <= i_sfr_wdata[EIC_PRIO_WIDTH-1:0];
        end
    end

    // edge/level mode bits in the timer control register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ext_irq_a_edge_mode_r <= 1'b0;
            ext_irq_b_edge_mode_r <= 1'b0;
        end else if (wr_tctl) begin
            ext_irq_a_edge_mode_r <= i_sfr_wdata[EIC_A_EDGE_BIT];
            ext_irq_b_edge_mode_r <= i_sfr_wdata[EIC_B_EDGE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the two external interrupt channels
    eic_channel u_chan_a (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_pins_sync  (pins_sync_r),
        .i_pin_select (pin_pol_cfg_r[EIC_A_SEL_HI:EIC_A_SEL_LO]),
        .i_polarity   (pin_pol_cfg_r[EIC_A_POL_BIT]),
        .i_edge_mode  (ext_irq_a_edge_mode_r),
        .i_vector_ack (i_ext_irq_a_vector_ack),
        .i_flag_wr    (wr_tctl),
        .i_flag_wdata (i_sfr_wdata[EIC_A_PEND_BIT]),
        .o_pending    (o_ext_irq_a_pending)
    );

    eic_channel u_chan_b (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_pins_sync  (pins_sync_r),
        .i_pin_select (pin_pol_cfg_r[EIC_B_SEL_HI:EIC_B_SEL_LO]),
        .i_polarity   (pin_pol_cfg_r[EIC_B_POL_BIT]),
        .i_edge_mode  (ext_irq_b_edge_mode_r),
        .i_vector_ack (i_ext_irq_b_vector_ack),
        .i_flag_wr    (wr_tctl),
        .i_flag_wdata (i_sfr_wdata[EIC_B_PEND_BIT]),
        .o_pending    (o_ext_irq_b_pending)
    );

    ////////////////////////////////////////////////////////////////////////
    // priority outputs straight from the register
    assign o_serial_periph_two_priority = ext_prio_two_r[EIC_PRIO_SPI_BIT];
    assign o_rtc_osc_fail_priority      = ext_prio_two_r[EIC_PRIO_RTC_BIT];
    assign o_port_match_priority        = ext_prio_two_r[EIC_PRIO_PORT_MATCH_PRIORITY_BIT];
    assign o_supply_warning_priority    = ext_prio_two_r[EIC_PRIO_WARN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // classify pending requests into high and low levels
    assign src_req  = {o_ext_irq_b_pending, o_ext_irq_a_pending,
                       i_serial_periph_two_req, i_rtc_osc_fail_req,
                       i_port_match_req, i_supply_warning_req};
    assign src_high = {i_ext_irq_b_high_pri, i_ext_irq_a_high_pri, ext_prio_two_r};

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            high_req_r <= 1'b0;
            low_req_r  <= 1'b0;
            preempt_r  <= 1'b0;
        end else begin
            high_req_r <= |(src_req & src_high);
            low_req_r  <= |(src_req & ~src_high) & ~|(src_req & src_high);
            preempt_r  <= |(src_req & src_high) & i_low_service_active;
        end
    end

    assign o_high_req    = high_req_r;
    assign o_low_req     = low_req_r;
    assign o_preempt_req = preempt_r;

    ////////////////////////////////////////////////////////////////////////
    // read mux, unmapped addresses read zero
    always_comb begin
        rd_mux = EIC_RDATA_IDLE;
        if (eic_hit(i_sfr_addr, EIC_ADDR_PIN_POL_CFG)) begin
            rd_mux = pin_pol_cfg_r;
        end else if (eic_hit(i_sfr_addr, EIC_ADDR_EXT_PRIO_TWO)) begin
            rd_mux = {4'h0, ext_prio_two_r};
        end else if (eic_hit(i_sfr_addr, EIC_ADDR_TIMER_CTRL)) begin
            rd_mux = {4'h0, o_ext_irq_b_pending, ext_irq_b_edge_mode_r,
                      o_ext_irq_a_pending, ext_irq_a_edge_mode_r};
        end
    end

    // registered read data
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_sfr_rdata <= EIC_RDATA_IDLE;
        end else if (i_sfr_rd) begin
            o_sfr_rdata <= rd_mux;
        end
    end

endmodule : eic_top

`default_nettype wire

// *** eic_pkg.sv ***
/*
 * shared constants for the external interrupt configuration block:
 * special-function register addresses, field positions and reset values.
 * assumes an 8-bit special-function register bus with 8-bit addresses.
 */
`default_nettype none

package eic_pkg;

    // register addresses on the special-function register bus
    localparam logic [7:0] EIC_ADDR_PIN_POL_CFG  = 8'he4;
    localparam logic [7:0] EIC_ADDR_EXT_PRIO_TWO = 8'hf7;
    localparam logic [7:0] EIC_ADDR_TIMER_CTRL   = 8'h88;

    // reset values
    localparam logic [7:0] EIC_RST_PIN_POL_CFG  = 8'h01;
    localparam logic [3:0] EIC_RST_EXT_PRIO_TWO = 4'h0;
    localparam logic [7:0] EIC_RDATA_IDLE       = 8'h00;

    // pin/polarity configuration fields
    localparam int EIC_B_POL_BIT   = 7;
    localparam int EIC_B_SEL_HI    = 6;
    localparam int EIC_B_SEL_LO    = 4;
    localparam int EIC_A_POL_BIT   = 3;
    localparam int EIC_A_SEL_HI    = 2;
    localparam int EIC_A_SEL_LO    = 0;

    // extended priority two fields
    localparam int EIC_PRIO_SPI_BIT  = 3;
    localparam int EIC_PRIO_RTC_BIT  = 2;
    localparam int EIC_PRIO_PORT_MATCH_PRIORITY_BIT = 1;
    localparam int EIC_PRIO_WARN_BIT = 0;
    localparam int EIC_PRIO_WIDTH    = 4;

    // timer control fields owned by this block
    localparam int EIC_A_EDGE_BIT = 0;
    localparam int EIC_A_PEND_BIT = 1;
    localparam int EIC_B_EDGE_BIT = 2;
    localparam int EIC_B_PEND_BIT = 3;

    // port width and selector width
    localparam int EIC_PORT_WIDTH = 8;
    localparam int EIC_SEL_WIDTH  = 3;

endpackage : eic_pkg

`default_nettype wire

// *** eic_channel.sv ***
/*
 * one external interrupt channel: picks a port pin, applies polarity,
 * and keeps the pending flag in edge or level mode.
 * assumes the port pins arrive already synchronised to i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module eic_channel
    import eic_pkg::*;
(
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    // configuration
    input  wire logic [EIC_PORT_WIDTH-1:0] i_pins_sync,
    input  wire logic [EIC_SEL_WIDTH-1:0]  i_pin_select,
    input  wire logic                      i_polarity,
    input  wire logic                      i_edge_mode,
    // flag control
    input  wire logic                      i_vector_ack,
    input  wire logic                      i_flag_wr,
    input  wire logic                      i_flag_wdata,
    // status
    output logic                           o_pending
);

    logic active;
    logic active_prev_r;
    logic pend_r;
    logic pend_nxt;
    logic rise;

    ////////////////////////////////////////////////////////////////////////
    // selected pin, observed only, never driven; polarity 1 = active high
    assign active = ~(i_pins_sync[i_pin_select] ^ i_polarity);
    assign rise   = active & ~active_prev_r;

    // previous active level for edge detection
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            active_prev_r <= 1'b0;
        end else begin
            active_prev_r <= active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending flag: level follows input, edge is sticky, set beats clear
    always_comb begin
        pend_nxt = pend_r;
        if (!i_edge_mode) begin
            pend_nxt = active;
        end else begin
            if (i_vector_ack) begin
                pend_nxt = 1'b0;
            end
            if (i_flag_wr) begin
                pend_nxt = i_flag_wdata;
            end
            if (rise) begin
                pend_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    assign o_pending = pend_r;

endmodule : eic_channel

`default_nettype wire

// *** eic_props.sv ***
/* checker for the external interrupt configuration block: port-level assertions.
   assumes it is bound to eic_top and sees one clock and a synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module eic_props
    import eic_pkg::*;
(
    // clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rst,
    // register bus
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic       i_sfr_rd,
    input wire logic [7:0] o_sfr_rdata,
    // priority inputs and requests
    input wire logic       i_ext_irq_a_high_pri,
    input wire logic       i_low_service_active,
    input wire logic       i_rtc_osc_fail_req,
    input wire logic       i_port_match_req,
    input wire logic       i_supply_warning_req,
    // flags and classified outputs
    input wire logic       o_ext_irq_a_pending,
    input wire logic       o_ext_irq_b_pending,
    input wire logic       o_serial_periph_two_priority,
    input wire logic       o_rtc_osc_fail_priority,
    input wire logic       o_port_match_priority,
    input wire logic       o_supply_warning_priority,
    input wire logic       o_high_req,
    input wire logic       o_low_req,
    input wire logic       o_preempt_req
);
    // one clock domain for every property
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_prio_wr;
        i_sfr_wr && i_sfr_addr == EIC_ADDR_EXT_PRIO_TWO |=> {o_serial_periph_two_priority,
            o_rtc_osc_fail_priority, o_port_match_priority, o_supply_warning_priority} == $past(i_sfr_wdata[3:0]);
    endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("priority bits differ from write");
    property p_prio_upper;
        i_sfr_rd && i_sfr_addr == EIC_ADDR_EXT_PRIO_TWO |=> o_sfr_rdata[7:4] == 4'h0;
    endproperty
    a_prio_upper: assert property (p_prio_upper) else $error("priority upper bits not zero");
    property p_pend_read;
        i_sfr_rd && i_sfr_addr == EIC_ADDR_TIMER_CTRL |=>
            o_sfr_rdata[1] == $past(o_ext_irq_a_pending) && o_sfr_rdata[3] == $past(o_ext_irq_b_pending);
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending bits wrong in timer control");
    property p_rdata_hold;
        !i_sfr_rd |=> $stable(o_sfr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
    property p_high_ext;
        o_ext_irq_a_pending && i_ext_irq_a_high_pri |=> o_high_req && !o_low_req;
    endproperty
    a_high_ext: assert property (p_high_ext) else $error("high external request not classed high");
    property p_high_pm;
        i_port_match_req && o_port_match_priority |=> o_high_req;
    endproperty
    a_high_pm: assert property (p_high_pm) else $error("port match high request missing");
    property p_low_warn;
        i_supply_warning_req && !o_supply_warning_priority |=> o_low_req || o_high_req;
    endproperty
    a_low_warn: assert property (p_low_warn) else $error("warning request lost");
    property p_preempt;
        i_rtc_osc_fail_req && o_rtc_osc_fail_priority && i_low_service_active |=> o_preempt_req;
    endproperty
    a_preempt: assert property (p_preempt) else $error("preempt request missing");
    property p_low_excl;
        o_low_req |-> !o_high_req && !o_preempt_req;
    endproperty
    a_low_excl: assert property (p_low_excl) else $error("low request alongside high");
endmodule : eic_props

bind eic_top eic_props u_eic_props (.i_mclk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd,
    .o_sfr_rdata, .i_ext_irq_a_high_pri, .i_low_service_active, .i_rtc_osc_fail_req, .i_port_match_req,
    .i_supply_warning_req, .o_ext_irq_a_pending, .o_ext_irq_b_pending, .o_serial_periph_two_priority,
    .o_rtc_osc_fail_priority, .o_port_match_priority, .o_supply_warning_priority, .o_high_req,
    .o_low_req, .o_preempt_req);
`default_nettype wire

// *** eic_pin_source.sv ***
/* external pin source model: drives port-0 pins toward a target pattern.
   assumes the bench sets the target and a lag of zero (prompt) or more (slow). */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module eic_pin_source (
    // clock and control
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_target,
    input  wire logic [3:0] i_lag,
    // driven pins
    output var logic  [7:0] o_port0_pins = 8'h00
);
    logic [3:0] wait_r = 4'h0;

    // each level is held until the bench changes it, after the lag
    always @(posedge i_mclk) begin
        if (o_port0_pins == i_target) begin
            wait_r <= 4'h0;
        end else if (wait_r >= i_lag) begin
            o_port0_pins <= i_target;
            wait_r       <= 4'h0;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : eic_pin_source
`default_nettype wire

// *** test_external_interrupt_config.sv ***
/* self-checking bench for the external interrupt configuration block.
   assumes eic_top, eic_pin_source and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module test_external_interrupt_config;
    import eic_pkg::*;
    logic       i_mclk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, pin_target = 8'h02, o_sfr_rdata, i_port0_pins;
    logic [3:0] pin_lag = 4'h0;
    logic       i_ext_irq_a_vector_ack = 1'b0, i_ext_irq_b_vector_ack = 1'b0, i_ext_irq_a_high_pri = 1'b0;
    logic       i_ext_irq_b_high_pri = 1'b0, i_low_service_active = 1'b0, i_serial_periph_two_req = 1'b0;
    logic       i_rtc_osc_fail_req = 1'b0, i_port_match_req = 1'b0, i_supply_warning_req = 1'b0;
    logic       o_ext_irq_a_pending, o_ext_irq_b_pending, o_serial_periph_two_priority, o_rtc_osc_fail_priority;
    logic       o_port_match_priority, o_supply_warning_priority, o_high_req, o_low_req, o_preempt_req;
    logic [7:0] d;
    int         failures = 0, samples_checked = 0;

    // clock, design and pin source
    always #2.5 i_mclk = ~i_mclk;
    eic_top u_eic_top (.i_mclk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata,
        .i_port0_pins, .i_ext_irq_a_vector_ack, .i_ext_irq_b_vector_ack, .i_ext_irq_a_high_pri,
        .i_ext_irq_b_high_pri, .i_low_service_active, .i_serial_periph_two_req, .i_rtc_osc_fail_req,
        .i_port_match_req, .i_supply_warning_req, .o_ext_irq_a_pending, .o_ext_irq_b_pending,
        .o_serial_periph_two_priority, .o_rtc_osc_fail_priority, .o_port_match_priority,
        .o_supply_warning_priority, .o_high_req, .o_low_req, .o_preempt_req);
    eic_pin_source u_eic_pin_source (.i_mclk, .i_target(pin_target), .i_lag(pin_lag), .o_port0_pins(i_port0_pins));

    ////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        i_sfr_addr  <= a;
        i_sfr_wdata <= v;
        i_sfr_wr    <= 1'b1;
        @(posedge i_mclk);
        i_sfr_wr <= 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_mclk);
        i_sfr_addr <= a;
        i_sfr_rd   <= 1'b1;
        @(posedge i_mclk);
        i_sfr_rd <= 1'b0;
        #1 v = o_sfr_rdata;
    endtask : sfr_rd
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick
    task automatic wait_pend(input logic ea, input logic eb);
        tick(1); // look after the flags settle, never in the launching step
        for (int n = 0; n < 20 && !(o_ext_irq_a_pending === ea && o_ext_irq_b_pending === eb); n++) tick(1);
        chk_bit(o_ext_irq_a_pending, ea);
        chk_bit(o_ext_irq_b_pending, eb);
    endtask : wait_pend
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////
    task automatic t_reset_and_prio;
        logic [7:0] vals [5] = '{8'hf1, 8'he2, 8'hd4, 8'hb8, 8'h00};
        sfr_rd(EIC_ADDR_PIN_POL_CFG, d);
        chk_byte(d, EIC_RST_PIN_POL_CFG);
        sfr_rd(EIC_ADDR_EXT_PRIO_TWO, d);
        chk_byte(d, 8'h00);
        sfr_rd(8'h55, d);
        chk_byte(d, EIC_RDATA_IDLE);
        foreach (vals[i]) begin
            sfr_wr(EIC_ADDR_EXT_PRIO_TWO, vals[i]);
            sfr_rd(EIC_ADDR_EXT_PRIO_TWO, d);
            chk_byte(d, {4'h0, vals[i][3:0]});
            chk_byte({4'h0, o_serial_periph_two_priority, o_rtc_osc_fail_priority, o_port_match_priority,
                o_supply_warning_priority}, {4'h0, vals[i][3:0]});
        end
    endtask : t_reset_and_prio
    task automatic t_level_select;
        for (int p = 0; p < 8; p++) begin
            pin_lag <= p[0] ? 4'h3 : 4'h0;
            sfr_wr(EIC_ADDR_PIN_POL_CFG, {p[0], 3'(7 - p), ~p[0], 3'(p)});
            i_ext_irq_a_high_pri <= p[0];
            pin_target <= p[0] ? ~(8'h01 << p) : (8'h01 << p);
            wait_pend(1'b1, 1'b1);
            sfr_wr(EIC_ADDR_TIMER_CTRL, 8'h00);
            sfr_rd(EIC_ADDR_TIMER_CTRL, d);
            chk_byte(d, 8'h0a);
            chk_bit(o_low_req, ~p[0]);
            chk_bit(o_high_req, p[0]);
            pin_target <= p[0] ? (8'h01 << p) : ~(8'h01 << p);
            wait_pend(1'b0, 1'b0);
        end
    endtask : t_level_select
    task automatic t_edge;
        sfr_wr(EIC_ADDR_PIN_POL_CFG, 8'h18);
        pin_target <= 8'h02;
        wait_pend(1'b0, 1'b0);
        sfr_wr(EIC_ADDR_TIMER_CTRL, 8'h05);
        pin_target <= 8'h01;
        wait_pend(1'b1, 1'b1);
        pin_target <= 8'h02;
        @(posedge i_mclk);
        i_ext_irq_b_high_pri <= 1'b1;
        i_low_service_active <= 1'b1;
        tick(6);
        wait_pend(1'b1, 1'b1);
        chk_byte({5'h0, o_high_req, o_low_req, o_preempt_req}, 8'h05);
        @(posedge i_mclk) i_ext_irq_a_vector_ack <= 1'b1;
        @(posedge i_mclk) i_ext_irq_a_vector_ack <= 1'b0;
        wait_pend(1'b0, 1'b1);
        @(posedge i_mclk) i_ext_irq_b_vector_ack <= 1'b1;
        @(posedge i_mclk) i_ext_irq_b_vector_ack <= 1'b0;
        wait_pend(1'b0, 1'b0);
    endtask : t_edge
    task automatic t_onchip;
        sfr_wr(EIC_ADDR_EXT_PRIO_TWO, 8'h06);
        i_port_match_req     <= 1'b1;
        i_supply_warning_req <= 1'b1;
        i_rtc_osc_fail_req   <= 1'b1;
        tick(2);
        chk_byte({5'h0, o_high_req, o_low_req, o_preempt_req}, 8'h05);
        @(posedge i_mclk);
        i_port_match_req     <= 1'b0;
        i_rtc_osc_fail_req   <= 1'b0;
        i_low_service_active <= 1'b0;
        tick(2);
        chk_byte({5'h0, o_high_req, o_low_req, o_preempt_req}, 8'h02);
        sfr_wr(EIC_ADDR_EXT_PRIO_TWO, 8'h08);
        i_serial_periph_two_req <= 1'b1;
        tick(2);
        chk_byte({5'h0, o_high_req, o_low_req, o_preempt_req}, 8'h04);
    endtask : t_onchip

    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_reset_and_prio();
        t_level_select();
        t_edge();
        t_onchip();
        end_sim();
    end
    initial begin
        #100000;
        failures++;
        end_sim();
    end
endmodule : test_external_interrupt_config
`default_nettype wire
